// File: ldpg_pkg.sv
// Constants, register map, modes and state record for the laser drive pulse and gate block.
// Assumes one 200 MHz clock, a synchronous high reset and a same-clock ADC word for the request.
// Function
// RQ1: Power-up: steady drive, output disabled, command only.
// RQ2: Steady drive starts after three-second safety delay.
// RQ3: Steady drive: min(setpoint, limit), slew limited.
// RQ4: Analog mode: min(sampled request, limit), setpoint ignored.
// RQ5: Request scales linearly: 100 mV per percent.
// RQ6: Request sampled at a fixed 100 Hz.
// RQ7: Source keeps request content below 50 Hz.
// RQ8: Request never enables output while interlocked or disabled.
// RQ9: Power-up: current feedback; power feedback by command.
// RQ10: Feedback source follows the selected regulation mode.
// RQ11: Five pulse behaviours; power-up continuous, pulses enabled.
// RQ12: Clearing pulse enable stops output in every behaviour.
// RQ13: Trigger high when driven high or open.
// RQ14: Period count is reciprocal of pulse rate.
// RQ15: Host programs width below period before timed use.
// RQ16: Trigger never enables output while interlocked.
// RQ17: Level follow: output exactly while trigger high.
// RQ18: Edge single: rising edge starts both timers, auto reload; the code reloads only on a rising edge after the period expires.
// RQ19: Timed behaviours drive only while width timer runs.
// RQ20: Edge single ignores edges until period expires.
// RQ21: Edge restart: every rising edge restarts both timers.
// RQ22: Self repeat ignores trigger, reloads on period expiry.
// RQ23: Width and period run as clock-cycle down-counters.
package ldpg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned SAFETY_DELAY_S = 3;
  localparam int unsigned SAFETY_CYCLES  = SAFETY_DELAY_S * CLK_HZ;
  localparam int unsigned SAMPLE_HZ      = 100;
  localparam int unsigned SAMPLE_CYCLES  = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned WIDTH_UNIT_NS  = 100;
  localparam int unsigned WIDTH_UNIT_CYC = WIDTH_UNIT_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned SLEW_PERIOD_NS = 1000;
  localparam int unsigned SLEW_CYCLES    = SLEW_PERIOD_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam logic [15:0] SLEW_STEP      = 16'h0010;
  localparam logic [31:0] CLK_HZ_W       = 32'h0bebc200;

  // ----------------------------------------------------------------
  // Current codes: one code is 0.01 % of full scale, which is 1 mV of request
  // ----------------------------------------------------------------
  localparam logic [15:0] FULL_SCALE     = 16'h2710;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_SETPOINT = 8'h04;
  localparam logic [7:0] REG_LIMIT    = 8'h08;
  localparam logic [7:0] REG_WIDTH    = 8'h0c;
  localparam logic [7:0] REG_RATE     = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_PERIOD   = 8'h18;
  localparam logic [7:0] REG_SAMPLE   = 8'h1c;
  localparam int CTRL_ANALOG   = 0;
  localparam int CTRL_POWER_FB = 1;
  localparam int CTRL_OUT_EN   = 2;
  localparam int CTRL_PULSE_EN = 3;
  localparam int CTRL_PSEL_LO  = 4;
  localparam logic RST_ANALOG   = 1'b0;
  localparam logic RST_POWER_FB = 1'b0;
  localparam logic RST_OUT_EN   = 1'b0;
  localparam logic RST_PULSE_EN = 1'b1;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PB_CONT    = 3'h0,
    PB_LEVEL   = 3'h1,
    PB_SINGLE  = 3'h2,
    PB_RESTART = 3'h3,
    PB_SELF    = 3'h4
  } ldpg_pulse_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'h1,
    DIV_RUN  = 2'h2
  } ldpg_div_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } ldpg_bus_t;

  typedef struct packed {
    logic        on;
    logic [15:0] level;
    logic        power_fb;
    logic        armed;
  } ldpg_drive_t;

  typedef struct packed {
    logic        analog;
    logic        power_fb;
    logic        out_en;
    logic        pulse_en;
    ldpg_pulse_t psel;
    logic [15:0] setpoint;
    logic [15:0] limit;
    logic [23:0] width_cmd;
    logic [31:0] rate_cmd;
    logic [31:0] period_cyc;
    logic [15:0] sample_mv;
    logic [31:0] sample_cnt;
    logic [15:0] level;
    logic [15:0] slew_cnt;
    logic [31:0] delay_cnt;
    logic        armed;
    logic        drive_on;
    logic [31:0] width_cnt;
    logic [31:0] period_cnt;
    logic        trig_meta;
    logic        trig_sync;
    logic        trig_prev;
    logic        ilk_meta;
    logic        ilk_sync;
    logic        dis_meta;
    logic        dis_sync;
    ldpg_div_t   div_st;
    logic [31:0] div_q;
    logic [32:0] div_rem;
    logic [31:0] div_d;
    logic [4:0]  div_n;
    logic [31:0] rdata;
  } ldpg_state_t;

endpackage

// File: ldpg_core.sv
// Enable, safety delay, drive source selection and pulse timers of the laser current driver.
// Assumes synchronised-here pins, a same-clock ADC request word in mV and a simple register port.
`timescale 1ns/10ps
module ldpg_core #(
  parameter int unsigned SAFETY_CYCLES = ldpg_pkg::SAFETY_CYCLES,
  parameter int unsigned SAMPLE_CYCLES = ldpg_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // Register port
  input  wire ldpg_pkg::ldpg_bus_t bus_i,
  output logic [31:0]            rdata_o,
  // Pins and converter
  input  wire logic              interlock_n_i,
  input  wire logic              out_disable_i,
  input  wire logic              trig_i,
  input  wire logic [13:0]       analog_mv_i,
  // Drive
  output ldpg_pkg::ldpg_drive_t  drive_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ldpg_pkg::ldpg_state_t s;
  ldpg_pkg::ldpg_state_t next_s;

  logic [31:0] width_cyc;
  logic [15:0] target;
  logic [15:0] clamp_mv;
  logic        cond_ok;
  logic        rise;
  logic        timed;
  logic        load;
  logic        gate;
  logic [32:0] rem_sh;

  assign width_cyc = 32'(s.width_cmd * ldpg_pkg::WIDTH_UNIT_CYC); // [RQ23]
  assign clamp_mv  = ({2'b00, analog_mv_i} > ldpg_pkg::FULL_SCALE) ? ldpg_pkg::FULL_SCALE
                     : {2'b00, analog_mv_i}; // [RQ5]
  assign cond_ok   = s.out_en && !s.ilk_sync && !s.dis_sync;
  assign rise      = s.trig_sync && !s.trig_prev;
  assign timed     = (s.psel == ldpg_pkg::PB_SINGLE) || (s.psel == ldpg_pkg::PB_RESTART)
                     || (s.psel == ldpg_pkg::PB_SELF);
  assign rem_sh    = {s.div_rem[31:0], s.div_q[31]};

  always_comb begin
    next_s = s;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // An open trigger pin is held high by its pull-up, so open reads as high.
    next_s.trig_meta = trig_i; // [RQ13]
    next_s.trig_sync = s.trig_meta;
    next_s.trig_prev = s.trig_sync;
    next_s.ilk_meta  = interlock_n_i;
    next_s.ilk_sync  = s.ilk_meta;
    next_s.dis_meta  = out_disable_i;
    next_s.dis_sync  = s.dis_meta;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (bus_i.we) begin
      case (bus_i.addr)
        ldpg_pkg::REG_CTRL: begin
          next_s.analog   = bus_i.wdata[ldpg_pkg::CTRL_ANALOG];   // [RQ1]
          next_s.power_fb = bus_i.wdata[ldpg_pkg::CTRL_POWER_FB]; // [RQ9]
          next_s.out_en   = bus_i.wdata[ldpg_pkg::CTRL_OUT_EN];
          next_s.pulse_en = bus_i.wdata[ldpg_pkg::CTRL_PULSE_EN];
          if (bus_i.wdata[ldpg_pkg::CTRL_PSEL_LO +: 3] <= 3'h4) begin
            next_s.psel = ldpg_pkg::ldpg_pulse_t'(bus_i.wdata[ldpg_pkg::CTRL_PSEL_LO +: 3]); // [RQ11]
          end
        end
        ldpg_pkg::REG_SETPOINT: begin
          next_s.setpoint = bus_i.wdata[15:0];
        end
        ldpg_pkg::REG_LIMIT: begin
          next_s.limit = bus_i.wdata[15:0];
        end
        ldpg_pkg::REG_WIDTH: begin
          next_s.width_cmd = bus_i.wdata[23:0];
        end
        ldpg_pkg::REG_RATE: begin
          next_s.rate_cmd = bus_i.wdata;
          if (bus_i.wdata == 32'h0) begin
            next_s.period_cyc = 32'h0;
            next_s.div_st     = ldpg_pkg::DIV_IDLE;
          end else begin
            next_s.div_d   = bus_i.wdata;
            next_s.div_q   = ldpg_pkg::CLK_HZ_W;
            next_s.div_rem = 33'h0;
            next_s.div_n   = 5'h0;
            next_s.div_st  = ldpg_pkg::DIV_RUN;
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Period from rate: one restoring division step per cycle
    // ----------------------------------------------------------------
    // Until the 32 steps finish the old period stays in use.
    case (s.div_st)
      ldpg_pkg::DIV_IDLE: begin
      end
      ldpg_pkg::DIV_RUN: begin
        if (!(bus_i.we && bus_i.addr == ldpg_pkg::REG_RATE)) begin
          if (rem_sh >= {1'b0, s.div_d}) begin
            next_s.div_rem = 33'(rem_sh - {1'b0, s.div_d});
            next_s.div_q   = {s.div_q[30:0], 1'b1};
          end else begin
            next_s.div_rem = rem_sh;
            next_s.div_q   = {s.div_q[30:0], 1'b0};
          end
          next_s.div_n = 5'(s.div_n + 5'h1);
          if (s.div_n == 5'h1f) begin
            next_s.period_cyc = next_s.div_q; // [RQ14]
            next_s.div_st     = ldpg_pkg::DIV_IDLE;
          end
        end
      end
      default: begin
        next_s.div_st = ldpg_pkg::DIV_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Request sampling and drive target
    // ----------------------------------------------------------------
    // No filtering here: the source must keep content below half the sample rate.
    if (s.sample_cnt >= 32'(SAMPLE_CYCLES - 1)) begin
      next_s.sample_cnt = 32'h0;
      next_s.sample_mv  = clamp_mv; // [RQ6] [RQ7]
    end else begin
      next_s.sample_cnt = 32'(s.sample_cnt + 32'h1);
    end
    if (s.analog) begin
      target = (s.sample_mv < s.limit) ? s.sample_mv : s.limit; // [RQ4]
    end else begin
      target = (s.setpoint < s.limit) ? s.setpoint : s.limit; // [RQ3]
    end
    if (target > ldpg_pkg::FULL_SCALE) begin
      target = ldpg_pkg::FULL_SCALE;
    end

    // Small steps trade settling speed for no overshoot into the diode.
    if (s.slew_cnt >= 16'(ldpg_pkg::SLEW_CYCLES - 1)) begin
      next_s.slew_cnt = 16'h0;
      if (target > s.level) begin
        next_s.level = (target - s.level > ldpg_pkg::SLEW_STEP)
                       ? 16'(s.level + ldpg_pkg::SLEW_STEP) : target; // [RQ3]
      end else begin
        next_s.level = (s.level - target > ldpg_pkg::SLEW_STEP)
                       ? 16'(s.level - ldpg_pkg::SLEW_STEP) : target;
      end
    end else begin
      next_s.slew_cnt = 16'(s.slew_cnt + 16'h1);
    end

    // ----------------------------------------------------------------
    // Safety delay
    // ----------------------------------------------------------------
    if (!cond_ok) begin
      next_s.delay_cnt = 32'h0;
      next_s.armed     = 1'b0; // [RQ8] [RQ16]
    end else if (!s.armed) begin
      if (s.delay_cnt >= 32'(SAFETY_CYCLES - 1)) begin
        next_s.armed = 1'b1; // [RQ2]
      end else begin
        next_s.delay_cnt = 32'(s.delay_cnt + 32'h1);
      end
    end

    // ----------------------------------------------------------------
    // Pulse timers
    // ----------------------------------------------------------------
    next_s.width_cnt  = (s.width_cnt != 32'h0) ? 32'(s.width_cnt - 32'h1) : 32'h0; // [RQ23]
    next_s.period_cnt = (s.period_cnt != 32'h0) ? 32'(s.period_cnt - 32'h1) : 32'h0;
    // Width must be shorter than period, or pulses run together.
    case (s.psel)
      ldpg_pkg::PB_SINGLE: begin
        load = rise && (s.period_cnt == 32'h0); // [RQ18] [RQ20] [RQ15]
      end
      ldpg_pkg::PB_RESTART: begin
        load = rise; // [RQ21]
      end
      ldpg_pkg::PB_SELF: begin
        // Reloading on the last count keeps the repeat at exactly the programmed period.
        load = (s.period_cnt <= 32'h1); // [RQ22]
      end
      default: begin
        load = 1'b0;
      end
    endcase
    if (!timed) begin
      next_s.width_cnt  = 32'h0;
      next_s.period_cnt = 32'h0;
    end else if (load && s.period_cyc != 32'h0) begin
      next_s.width_cnt  = width_cyc; // [RQ18]
      next_s.period_cnt = s.period_cyc;
    end

    // ----------------------------------------------------------------
    // Output gate
    // ----------------------------------------------------------------
    case (s.psel)
      ldpg_pkg::PB_CONT: begin
        gate = 1'b1;
      end
      ldpg_pkg::PB_LEVEL: begin
        gate = s.trig_sync; // [RQ17]
      end
      default: begin
        gate = (s.width_cnt != 32'h0); // [RQ19]
      end
    endcase
    next_s.drive_on = s.armed && cond_ok && s.pulse_en && gate; // [RQ12] [RQ16] [RQ8]

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    next_s.rdata = 32'h0;
    if (bus_i.re) begin
      case (bus_i.addr)
        ldpg_pkg::REG_CTRL: begin
          next_s.rdata = {25'h0, s.psel, s.pulse_en, s.out_en, s.power_fb, s.analog};
        end
        ldpg_pkg::REG_SETPOINT: next_s.rdata = {16'h0, s.setpoint};
        ldpg_pkg::REG_LIMIT:    next_s.rdata = {16'h0, s.limit};
        ldpg_pkg::REG_WIDTH:    next_s.rdata = {8'h0, s.width_cmd};
        ldpg_pkg::REG_RATE:     next_s.rdata = s.rate_cmd;
        ldpg_pkg::REG_STATUS: begin
          next_s.rdata = {s.level, 8'h0, (s.div_st == ldpg_pkg::DIV_RUN), s.trig_sync,
                          s.dis_sync, !s.ilk_sync, (s.period_cnt != 32'h0),
                          (s.width_cnt != 32'h0), s.drive_on, s.armed};
        end
        ldpg_pkg::REG_PERIOD:   next_s.rdata = s.period_cyc;
        ldpg_pkg::REG_SAMPLE:   next_s.rdata = {16'h0, s.sample_mv};
        default:                next_s.rdata = 32'h0;
      endcase
    end

    // ----------------------------------------------------------------
    // Synchronous reset
    // ----------------------------------------------------------------
    if (rst_i) begin
      next_s          = '0;
      next_s.analog   = ldpg_pkg::RST_ANALOG;   // [RQ1]
      next_s.power_fb = ldpg_pkg::RST_POWER_FB; // [RQ9]
      next_s.out_en   = ldpg_pkg::RST_OUT_EN;   // [RQ1] [RQ11]
      next_s.pulse_en = ldpg_pkg::RST_PULSE_EN; // [RQ11]
      next_s.psel     = ldpg_pkg::PB_CONT;
      next_s.div_st   = ldpg_pkg::DIV_IDLE;
      next_s.limit    = ldpg_pkg::FULL_SCALE;
      next_s.ilk_meta = 1'b1;
      next_s.ilk_sync = 1'b1;
      next_s.trig_meta = 1'b1;
      next_s.trig_sync = 1'b1;
      next_s.trig_prev = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    s <= next_s;
  end

  assign rdata_o        = s.rdata;
  assign drive_o = '{on: s.drive_on, level: s.level, power_fb: s.power_fb, armed: s.armed}; // [RQ10]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_reset_defaults: assert property ($fell(rst_i) |-> !s.analog && !s.out_en && s.pulse_en && !s.power_fb && s.psel == ldpg_pkg::PB_CONT) // [RQ1]
    else $error("Power-up defaults wrong.");
  a_arm_after_delay: assert property ($rose(s.armed) |-> $past(s.delay_cnt) >= 32'(SAFETY_CYCLES - 1)) // [RQ2]
    else $error("Armed before safety delay.");
  a_slew_bounded: assert property (s.level > $past(s.level) |-> s.level - $past(s.level) <= ldpg_pkg::SLEW_STEP) // [RQ3]
    else $error("Level rose faster than slew step.");
  a_sample_taken: assert property (s.sample_cnt == 32'(SAMPLE_CYCLES - 1) |=> s.sample_mv == $past(clamp_mv)) // [RQ6]
    else $error("Request not sampled.");
  a_interlock_off: assert property (!cond_ok |=> !s.drive_on) // [RQ8]
    else $error("Drive on while interlocked or disabled.");
  a_pulse_disable: assert property (!s.pulse_en |=> !s.drive_on) // [RQ12]
    else $error("Drive on with pulses disabled.");
  a_level_follow: assert property (s.psel == ldpg_pkg::PB_LEVEL && s.armed && cond_ok && s.pulse_en |=> s.drive_on == $past(s.trig_sync)) // [RQ17]
    else $error("Drive does not follow trigger.");
  a_width_gate: assert property (timed && s.width_cnt == 32'h0 |=> !s.drive_on) // [RQ19]
    else $error("Drive on with width timer stopped.");
  a_single_ignore: assert property (s.psel == ldpg_pkg::PB_SINGLE && rise && s.period_cnt != 32'h0 && !bus_i.we |=> s.period_cnt == $past(s.period_cnt) - 32'h1) // [RQ20]
    else $error("Edge accepted while period running.");
  a_restart_load: assert property (s.psel == ldpg_pkg::PB_RESTART && rise && s.period_cyc != 32'h0 && !bus_i.we |=> s.width_cnt == $past(width_cyc) && s.period_cnt == $past(s.period_cyc)) // [RQ21]
    else $error("Edge did not restart timers.");
  a_self_reload: assert property (s.psel == ldpg_pkg::PB_SELF && s.period_cnt <= 32'h1 && s.period_cyc != 32'h0 && !bus_i.we |=> s.period_cnt == $past(s.period_cyc)) // [RQ22]
    else $error("Self repeat did not reload.");

  c_restart_stretch: cover property (s.psel == ldpg_pkg::PB_RESTART && rise && s.width_cnt != 32'h0);
  c_single_ignored:  cover property (s.psel == ldpg_pkg::PB_SINGLE && rise && s.period_cnt != 32'h0);
  c_self_pulse:      cover property (s.psel == ldpg_pkg::PB_SELF && $rose(s.drive_on));

endmodule

// File: ldpg_pins.sv
// Pin-side partner: interlock switch, disable pin, trigger source and request voltage.
// Assumes the bench moves its controls right after rising clock edges.
`timescale 1ns/10ps
module ldpg_pins (
  // Controls from the bench
  input  wire logic        ilk_gnd_i,
  input  wire logic        dis_i,
  input  wire logic [1:0]  trig_sel_i,
  input  wire logic [13:0] req_mv_i,
  // Pins of the block
  output logic             interlock_n_o,
  output logic             out_disable_o,
  output logic             trig_o,
  output logic [13:0]      analog_mv_o
);
  // The interlock line floats high unless it is grounded.
  assign interlock_n_o = ~ilk_gnd_i;
  assign out_disable_o = dis_i;
  // Select 0 grounds the trigger, 1 drives it high, 2 leaves it open to the pull-up.
  assign trig_o        = (trig_sel_i != 2'h0);
  // Steps are held for many sample periods, so nothing lies above half the sample rate.
  assign analog_mv_o   = req_mv_i;
endmodule

// File: tb_laser_drive_pulse_gate_control.sv
// Self-checking bench for the laser drive pulse and gate core.
// Assumes short safety and sample counts; the pin partner sits in ldpg_pins.
`timescale 1ns/10ps
module tb_laser_drive_pulse_gate_control;
  localparam int SAFE = 20;
  localparam int WID  = 2;
  localparam int PW   = WID * 20;
  localparam int PER  = 200;
  logic                  ref_clk_i;
  logic                  rst_i;
  ldpg_pkg::ldpg_bus_t   bus;
  logic [31:0]           rdata;
  ldpg_pkg::ldpg_drive_t drv;
  logic                  ilk_gnd;
  logic                  dis;
  logic [1:0]            tsel;
  logic [13:0]           req;
  logic                  ilk_n;
  logic                  dis_pin;
  logic                  trig;
  logic [13:0]           amv;
  int                    n_mismatch = 0;
  int                    total_checks = 0;
  int                    cyc = 0;
  int                    len;
  int                    gap;

  ldpg_core #(.SAFETY_CYCLES(SAFE), .SAMPLE_CYCLES(10)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .interlock_n_i(ilk_n), .out_disable_i(dis_pin), .trig_i(trig),
    .analog_mv_i(amv), .drive_o(drv));
  ldpg_pins pins (
    .ilk_gnd_i(ilk_gnd), .dis_i(dis), .trig_sel_i(tsel), .req_mv_i(req),
    .interlock_n_o(ilk_n), .out_disable_o(dis_pin), .trig_o(trig), .analog_mv_o(amv));

  // --------------------------------
  // Clock, timeout and helpers
  // --------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // The tests need about 4300 cycles; the ceiling leaves room for slow pulses.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge ref_clk_i);
    bus.we <= 1'b0;
  endtask

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] exp);
    @(posedge ref_clk_i);
    bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge ref_clk_i);
    bus.re <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Waits for the gate to open, then counts how long it stays open.
  task automatic meas(output int n);
    int t;
    n = 0;
    t = 0;
    while (drv.on !== 1'b1 && t < 600) begin
      wait_n(1);
      t++;
    end
    while (drv.on === 1'b1 && n < 2000) begin
      wait_n(1);
      n++;
    end
  endtask

  // Two trigger rises twelve cycles apart; a second rise restarts or is ignored.
  task automatic edge_run(logic [31:0] m, int exp);
    wr(ldpg_pkg::REG_CTRL, 32'h0c | (m << 4));
    fork
      meas(len);
      begin
        @(posedge ref_clk_i) tsel <= 2'h1;
        repeat (2) @(posedge ref_clk_i);
        tsel <= 2'h0;
        repeat (10) @(posedge ref_clk_i);
        tsel <= 2'h1;
        repeat (4) @(posedge ref_clk_i);
        tsel <= 2'h0;
      end
    join
    chk("pulse", len, exp);
    wait_n(PER);
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    bus = '0;
    rst_i = 1'b1;
    ilk_gnd = 1'b0;
    dis = 1'b0;
    tsel = 2'h0;
    req = 14'h0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wait_n(1);
    chk("on", drv.on, 32'h0);
    chk("pfb", drv.power_fb, 32'h0);
    rdc("ctrl", ldpg_pkg::REG_CTRL, 32'h08);
    rdc("limit", ldpg_pkg::REG_LIMIT, 32'h2710);
    rdc("unmapped", 8'h20, 32'h0);
    wr(ldpg_pkg::REG_LIMIT, 32'h40);
    wr(ldpg_pkg::REG_SETPOINT, 32'h100);
    @(posedge ref_clk_i) ilk_gnd <= 1'b1;
    wr(ldpg_pkg::REG_CTRL, 32'h0c);
    len = 0;
    while (drv.armed !== 1'b1 && len < 200) begin
      wait_n(1);
      len++;
    end
    chk("delay", len >= SAFE, 32'h1);
    wait_n(2);
    chk("on", drv.on, 32'h1);
    wait_n(2000);
    chk("level", drv.level, 32'h40);
    rdc("status", ldpg_pkg::REG_STATUS, 32'h00400013);
    @(posedge ref_clk_i) req <= 14'd30;
    wr(ldpg_pkg::REG_CTRL, 32'h0d);
    wait_n(1200);
    chk("level", drv.level, 32'h1e);
    rdc("sample", ldpg_pkg::REG_SAMPLE, 32'd30);
    wr(ldpg_pkg::REG_CTRL, 32'h0f);
    wait_n(2);
    chk("pfb", drv.power_fb, 32'h1);
    wr(ldpg_pkg::REG_CTRL, 32'h0c);
    @(posedge ref_clk_i) dis <= 1'b1;
    wait_n(6);
    chk("on", drv.on, 32'h0);
    @(posedge ref_clk_i) dis <= 1'b0;
    wait_n(40);
    wr(ldpg_pkg::REG_CTRL, 32'h04);
    wait_n(4);
    chk("on", drv.on, 32'h0);
    wr(ldpg_pkg::REG_CTRL, 32'h1c);
    wait_n(6);
    chk("on", drv.on, 32'h0);
    @(posedge ref_clk_i) tsel <= 2'h2;
    wait_n(6);
    chk("on", drv.on, 32'h1);
    @(posedge ref_clk_i) ilk_gnd <= 1'b0;
    wait_n(6);
    chk("on", drv.on, 32'h0);
    @(posedge ref_clk_i) ilk_gnd <= 1'b1;
    @(posedge ref_clk_i) tsel <= 2'h0;
    wait_n(40);
    // The width is kept below the period so every timed pulse ends before the next.
    wr(ldpg_pkg::REG_WIDTH, WID);
    wr(ldpg_pkg::REG_RATE, 32'd1000000);
    wait_n(40);
    rdc("period", ldpg_pkg::REG_PERIOD, PER);
    edge_run(32'h2, PW);
    edge_run(32'h3, PW + 12);
    wr(ldpg_pkg::REG_CTRL, 32'h4c);
    meas(len);
    gap = 0;
    while (drv.on !== 1'b1 && gap < 1000) begin
      wait_n(1);
      gap++;
    end
    meas(len);
    chk("gap", gap, PER - PW);
    chk("width", len, PW);
    wr(ldpg_pkg::REG_CTRL, 32'h7c);
    rdc("badmode", ldpg_pkg::REG_CTRL, 32'h4c);
    end_of_test();
  end
endmodule
